// ### rtl/drc_pkg.sv
package drc_pkg;
   localparam int          WORD_AW        = 14;
   localparam int          MUX_AW         = 7;
   localparam int          BUS_AW         = 19;
   localparam int          RANGE_W        = 5;
   localparam logic [4:0]  RAM_RANGE      = 5'h00;
   localparam real         CLK_MHZ        = 10.0;
   localparam real         DOC_CLK_MHZ    = 22.008;
   localparam real         REFRESH_US     = 15.6;
   localparam int          REFRESH_CYC    = int'($floor(REFRESH_US * CLK_MHZ));
   localparam int          TMR_W          = 12;
   localparam logic [11:0] REFRESH_TICKS  = 12'(REFRESH_CYC);
   localparam int          STEP_W         = 3;
   localparam logic [2:0]  RAS_CYC        = 3'h2;
   localparam logic [2:0]  CAS_CYC        = 3'h2;
   localparam logic [2:0]  RFSH_RAS_CYC   = 3'h3;
   localparam logic [2:0]  STEP_ONE       = 3'h1;

   typedef enum logic [3:0] {
      DRC_IDLE     = 4'b0000,
      DRC_ROW      = 4'b0001,
      DRC_SYS_ACK     = 4'b0010,
      DRC_RAS      = 4'b0011,
      DRC_COL      = 4'b0100,
      DRC_WE       = 4'b0101,
      DRC_CAS      = 4'b0110,
      DRC_XFER_ACK     = 4'b0111,
      DRC_RF_ADDR  = 4'b1000,
      DRC_RF_RAS   = 4'b1001
   } drc_state_e;

   typedef struct packed {
      logic       ras_n;
      logic       cas_n;
      logic       we_n;
   } drc_strobe_s;

   typedef struct packed {
      logic       sys_ack;
      logic       xfer_ack;
      logic       bus_ack_out;
      logic       rd_latch;
      logic       rd_drive;
   } drc_ack_s;
endpackage : drc_pkg

// ### rtl/drc_controller.sv
// Operation
// - read: address first, ack then data
// - write: same order, master supplies data
// - act only in range with command
// - two flops synchronise read and write
// - low seven bits row, upper column
// - no request breaks running cycle
// - refresh requests generated internally
// - refresh restarts timer, advances row
// - sequencer drives ras, cas, we
// - make sys and xfer ack, mux select
// - read latch and drive controls
// - single controller clock for everything
// - access wins over simultaneous refresh
// - write step order ends in idle
// - read same order without we
// - refresh: counter address, ras only
`timescale 1ns/1ps
`default_nettype none
module drc_controller
   import drc_pkg::*;
(
   input  wire logic                i_clock,
   input  wire logic                i_reset_n,
   input  wire logic [BUS_AW-1:0]   i_bus_addr,
   input  wire logic                i_mem_read_cmd_n,
   input  wire logic                i_mem_write_cmd_n,
   output var  logic [MUX_AW-1:0]   o_dram_mux_addr,
   output var  drc_strobe_s         o_strobe,
   output var  drc_ack_s            o_ack,
   output var  logic                o_mux_col_sel
);

   // state group decodes
   function automatic logic f_in_access(input drc_state_e s);
      f_in_access = (s != DRC_IDLE) && (s != DRC_RF_ADDR) && (s != DRC_RF_RAS);
   endfunction : f_in_access

   function automatic logic f_col_phase(input drc_state_e s);
      f_col_phase = (s == DRC_COL) || (s == DRC_WE) || (s == DRC_CAS) || (s == DRC_XFER_ACK);
   endfunction : f_col_phase

   function automatic logic f_rf_phase(input drc_state_e s);
      f_rf_phase = (s == DRC_RF_ADDR) || (s == DRC_RF_RAS);
   endfunction : f_rf_phase

   function automatic logic f_timed(input drc_state_e s);
      f_timed = (s == DRC_RAS) || (s == DRC_CAS) || (s == DRC_RF_RAS);
   endfunction : f_timed

   function automatic logic f_cas_phase(input drc_state_e s);
      f_cas_phase = (s == DRC_CAS) || (s == DRC_XFER_ACK);
   endfunction : f_cas_phase

   function automatic logic [STEP_W-1:0] f_width(input drc_state_e s);
      case (s)
         DRC_RAS:    f_width = RAS_CYC;
         DRC_CAS:    f_width = CAS_CYC;
         DRC_RF_RAS: f_width = RFSH_RAS_CYC;
         default:    f_width = '0;
      endcase
   endfunction : f_width

   // two-stage request synchroniser, slot 0 read, slot 1 write
   wire  [1:0] cmd_n = {i_mem_write_cmd_n, i_mem_read_cmd_n};
   wire  [1:0] req_sync;

   genvar g;
   generate
      for (g = 0; g < $bits(cmd_n); g++) begin : g_sync
         logic meta_q;
         logic sync_q;

         always_ff @(posedge i_clock or negedge i_reset_n) begin
            if (!i_reset_n) begin
               meta_q <= 1'b0;
               sync_q <= 1'b0;
            end else begin
               meta_q <= ~cmd_n[g];
               sync_q <= meta_q;
            end
         end

         assign req_sync[g] = sync_q;
      end
   endgenerate

   wire rd_sync_q = req_sync[0];
   wire wr_sync_q = req_sync[1];

   // address decode and split
   wire             in_range  = (i_bus_addr[BUS_AW-1 -: RANGE_W] == RAM_RANGE);
   wire [WORD_AW-1:0] word_addr = i_bus_addr[WORD_AW-1:0];
   wire [MUX_AW-1:0] row_addr = word_addr[MUX_AW-1:0];
   wire [MUX_AW-1:0] col_addr = word_addr[WORD_AW-1:MUX_AW];
   wire             rd_req    = rd_sync_q & in_range;
   wire             wr_req    = wr_sync_q & in_range & ~rd_req;

   // refresh timer and row counter
   logic [TMR_W-1:0]  tmr_q;
   logic [MUX_AW-1:0] rf_row_q;
   logic              rf_pend_q;
   drc_state_e        state_q, state_d;
   logic [STEP_W-1:0] step_q;
   logic              is_write_q;
   logic              served_q;

   wire tmr_done   = (tmr_q == REFRESH_TICKS);
   wire rf_start   = (state_q == DRC_RF_ADDR);
   wire idle       = (state_q == DRC_IDLE);
   wire access_go  = idle & (rd_req | wr_req) & ~served_q;
   wire refresh_go = idle & ~access_go & (rf_pend_q | tmr_done);
   wire step_done  = (step_q == STEP_ONE);
   // refresh row moves on only once the row strobe is over
   wire rf_end     = (state_q == DRC_RF_RAS) & step_done;

   // interval timer, restarted by each refresh
   always_ff @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         tmr_q <= '0;
      end else begin
         tmr_q <= (rf_start | tmr_done) ? '0 : tmr_q + 1'b1;
      end
   end

   // refresh row counter
   always_ff @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         rf_row_q <= '0;
      end else begin
         rf_row_q <= rf_end ? rf_row_q + 1'b1 : rf_row_q;
      end
   end

   // pending refresh, set wins over clear
   always_ff @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         rf_pend_q <= 1'b0;
      end else begin
         rf_pend_q <= tmr_done | (rf_pend_q & ~rf_start);
      end
   end

   // cycle sequencer; only idle looks at new requests
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         DRC_IDLE: begin
            if (access_go) begin
               state_d = DRC_ROW;
            end else if (refresh_go) begin
               state_d = DRC_RF_ADDR;
            end
         end
         DRC_ROW: begin
            state_d = DRC_SYS_ACK;
         end
         DRC_SYS_ACK: begin
            state_d = DRC_RAS;
         end
         DRC_RAS: begin
            if (step_done) begin
               state_d = DRC_COL;
            end
         end
         DRC_COL: begin
            state_d = is_write_q ? DRC_WE : DRC_CAS;
         end
         DRC_WE: begin
            state_d = DRC_CAS;
         end
         DRC_CAS: begin
            if (step_done) begin
               state_d = DRC_XFER_ACK;
            end
         end
         DRC_XFER_ACK: begin
            state_d = DRC_IDLE;
         end
         DRC_RF_ADDR: begin
            state_d = DRC_RF_RAS;
         end
         DRC_RF_RAS: begin
            if (step_done) begin
               state_d = DRC_IDLE;
            end
         end
         default: begin
            state_d = DRC_IDLE;
         end
      endcase
   end

   // width counter for strobe phases
   wire              step_entry = f_timed(state_d) & (state_d != state_q);
   wire [STEP_W-1:0] step_load  = step_entry ? f_width(state_d) : '0;
   wire              step_run   = f_timed(state_q);

   // state register
   always_ff @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         state_q <= DRC_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   // strobe width counter
   always_ff @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         step_q <= '0;
      end else begin
         step_q <= (step_load != '0) ? step_load : (step_run ? step_q - STEP_ONE : step_q);
      end
   end

   // direction of the granted access
   wire is_write_d = access_go ? wr_req : is_write_q;

   always_ff @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         is_write_q <= 1'b0;
      end else begin
         is_write_q <= is_write_d;
      end
   end

   // command already answered, held until released
   always_ff @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         served_q <= 1'b0;
      end else begin
         served_q <= access_go | (served_q & (rd_sync_q | wr_sync_q));
      end
   end

   // outputs derived from next state, registered
   wire in_access  = f_in_access(state_d);
   wire col_phase  = f_col_phase(state_d);
   wire rf_phase   = f_rf_phase(state_d);
   wire ras_on     = (in_access & (state_d != DRC_ROW) & (state_d != DRC_SYS_ACK)) | (state_d == DRC_RF_RAS);
   wire cas_on     = f_cas_phase(state_d);
   wire we_on      = is_write_d & ((state_d == DRC_WE) | cas_on);
   wire sys_ack_on    = in_access & (state_d != DRC_ROW);
   wire xfer_ack_on    = (state_d == DRC_XFER_ACK);
   wire rd_pulse   = xfer_ack_on & ~is_write_d;
   wire [MUX_AW-1:0] addr_d = rf_phase ? rf_row_q : (col_phase ? col_addr : row_addr);

   // address lines and multiplexer select
   always_ff @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_dram_mux_addr <= '0;
         o_mux_col_sel   <= 1'b0;
      end else begin
         o_dram_mux_addr <= addr_d;
         o_mux_col_sel   <= col_phase;
      end
   end

   // memory strobes
   always_ff @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_strobe <= '{ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1};
      end else begin
         o_strobe.ras_n <= ~ras_on;
         o_strobe.cas_n <= ~cas_on;
         o_strobe.we_n  <= ~we_on;
      end
   end

   // acknowledges and read data controls
   always_ff @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_ack <= '0;
      end else begin
         o_ack.sys_ack     <= sys_ack_on;
         o_ack.xfer_ack    <= xfer_ack_on;
         o_ack.bus_ack_out <= sys_ack_on;
         o_ack.rd_latch    <= rd_pulse;
         o_ack.rd_drive    <= rd_pulse;
      end
   end

endmodule : drc_controller
`default_nettype wire

// ### tb/drc_checker_sva.sv
`timescale 1ns/1ps
`default_nettype none
module drc_checker
   import drc_pkg::*;
(
   input wire logic              i_clock,
   input wire logic              i_reset_n,
   input wire logic [BUS_AW-1:0] i_bus_addr,
   input wire logic              i_mem_read_cmd_n,
   input wire logic              i_mem_write_cmd_n,
   input wire logic [MUX_AW-1:0] o_dram_mux_addr,
   input wire drc_strobe_s       o_strobe,
   input wire drc_ack_s          o_ack,
   input wire logic              o_mux_col_sel
);
   default clocking @(posedge i_clock); endclocking
   default disable iff (!i_reset_n);
   wire logic in_rng = i_bus_addr[18:14] == RAM_RANGE;
   a_ack_bound: assert property ($fell(i_mem_read_cmd_n & i_mem_write_cmd_n) && in_rng |-> ##[1:24] o_ack.xfer_ack)
      else $error("no transfer ack after command");
   a_range_only: assert property (!in_rng [*6] |-> !$rose(o_ack.sys_ack))
      else $error("ack for out of range address");
   a_row_first: assert property ($rose(o_ack.sys_ack) |-> o_dram_mux_addr == i_bus_addr[6:0])
      else $error("row address wrong at system ack");
   a_col_addr: assert property (o_mux_col_sel |-> o_dram_mux_addr == i_bus_addr[13:7])
      else $error("column address wrong");
   a_xfer_pulse: assert property (o_ack.xfer_ack |=> !o_ack.xfer_ack)
      else $error("transfer ack longer than one cycle");
   a_xfer_in_sys_ack: assert property (o_ack.xfer_ack |-> o_ack.sys_ack && o_ack.bus_ack_out)
      else $error("transfer ack outside system ack");
   a_we_write: assert property (!o_strobe.we_n |-> !i_mem_write_cmd_n && o_ack.sys_ack)
      else $error("write enable without write");
   a_rd_latch: assert property (o_ack.rd_latch |-> o_ack.xfer_ack && !i_mem_read_cmd_n)
      else $error("read latch outside read ack");
   a_refresh_ras: assert property (!o_strobe.ras_n && !o_ack.sys_ack |-> o_strobe.cas_n && o_strobe.we_n)
      else $error("refresh drives more than row strobe");
   a_rf_addr_hold: assert property (!o_strobe.ras_n && !$past(o_strobe.ras_n) && !o_ack.sys_ack |-> $stable(o_dram_mux_addr))
      else $error("refresh address moved during row strobe");
   c_write: cover property (!o_strobe.we_n);
   c_read: cover property (o_ack.rd_latch);
   c_refresh: cover property (!o_strobe.ras_n && !o_ack.sys_ack);
endmodule : drc_checker
bind drc_controller drc_checker i_chk (.i_clock(i_clock), .i_reset_n(i_reset_n), .i_bus_addr(i_bus_addr),
   .i_mem_read_cmd_n(i_mem_read_cmd_n), .i_mem_write_cmd_n(i_mem_write_cmd_n), .o_strobe(o_strobe),
   .o_dram_mux_addr(o_dram_mux_addr), .o_ack(o_ack), .o_mux_col_sel(o_mux_col_sel));
`default_nettype wire

// ### tb/drc_bus_master.sv
`timescale 1ns/1ps
`default_nettype none
module drc_bus_master
   import drc_pkg::*;
(
   input  wire logic              i_clock,
   input  wire logic [MUX_AW-1:0] i_dram_mux_addr,
   input  wire drc_strobe_s       i_strobe,
   input  wire drc_ack_s          i_ack,
   input  wire logic              i_mux_col_sel,
   output var  logic [BUS_AW-1:0] o_bus_addr,
   output var  logic              o_mem_read_cmd_n,
   output var  logic              o_mem_write_cmd_n
);
   initial begin
      o_bus_addr = '1;
      o_mem_read_cmd_n = 1'b1;
      o_mem_write_cmd_n = 1'b1;
   end
   task automatic access(input logic wr, input logic [BUS_AW-1:0] a, output logic [MUX_AW-1:0] row,
                         output logic [MUX_AW-1:0] col, output logic we, output logic rd, output logic got);
      {got, we, rd, row, col} = '0;
      @(posedge i_clock);
      #10;
      o_bus_addr = a;
      o_mem_read_cmd_n = wr;
      o_mem_write_cmd_n = !wr;
      for (int k = 0; k < 30 && !got; k++) begin
         @(posedge i_clock);
         if (i_ack.sys_ack && !i_strobe.ras_n && !i_mux_col_sel) row = i_dram_mux_addr;
         if (i_mux_col_sel) col = i_dram_mux_addr;
         if (!i_strobe.we_n) we = 1'b1;
         if (i_ack.xfer_ack) begin
            got = 1'b1;
            rd = i_ack.rd_latch & i_ack.rd_drive;
         end
      end
      #10;
      o_mem_read_cmd_n = 1'b1;
      o_mem_write_cmd_n = 1'b1;
      o_bus_addr = ~a;
   endtask : access
endmodule : drc_bus_master
`default_nettype wire

// ### tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import drc_pkg::*;
   typedef struct packed {logic wr; logic [13:0] a; logic [6:0] row; logic [6:0] col;} drc_row_s;
   drc_row_s           rows [4] = '{'{1'b1, 14'h3fff, 7'h7f, 7'h7f}, '{1'b0, 14'h2a55, 7'h55, 7'h54},
                                    '{1'b1, 14'h0081, 7'h01, 7'h01}, '{1'b0, 14'h1f80, 7'h00, 7'h3f}};
   logic               i_clock = 1'b0;
   logic               i_reset_n = 1'b0;
   logic [BUS_AW-1:0]  bus_addr;
   logic               rd_n, wr_n, col_sel, we, rd, got, ras_q;
   logic [MUX_AW-1:0]  mux_addr, row, col, last_rf;
   drc_strobe_s        strobe;
   drc_ack_s           ack;
   int                 n_errors = 0;
   int                 comparisons = 0;
   int                 n_rf = 0;
   always #50 i_clock = ~i_clock;
   drc_controller i_dut (.i_clock(i_clock), .i_reset_n(i_reset_n), .i_bus_addr(bus_addr),
      .i_mem_read_cmd_n(rd_n), .i_mem_write_cmd_n(wr_n), .o_dram_mux_addr(mux_addr),
      .o_strobe(strobe), .o_ack(ack), .o_mux_col_sel(col_sel));
   drc_bus_master i_master (.i_clock(i_clock), .i_dram_mux_addr(mux_addr), .i_strobe(strobe), .i_ack(ack),
      .i_mux_col_sel(col_sel), .o_bus_addr(bus_addr), .o_mem_read_cmd_n(rd_n), .o_mem_write_cmd_n(wr_n));
   task check(input string what, input logic [18:0] seen, input logic [18:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task conclude;
      $display("comparisons %0d mismatches %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : conclude
   always @(posedge i_clock) begin
      if (!i_reset_n) n_rf = 0;
      else if (ras_q && !strobe.ras_n && !ack.sys_ack) begin
         if (n_rf > 0) check("refresh row", mux_addr, 7'(last_rf + 7'h01));
         last_rf = mux_addr;
         n_rf++;
      end
      ras_q = strobe.ras_n;
   end
   initial begin
      repeat (4) @(posedge i_clock);
      #10;
      i_reset_n = 1'b1;
      foreach (rows[i]) begin
         i_master.access(rows[i].wr, {5'h00, rows[i].a}, row, col, we, rd, got);
         check("ack", got, 1'b1);
         if (!got) conclude();
         check("row", row, rows[i].row);
         check("col", col, rows[i].col);
         check("we", we, rows[i].wr);
         check("rd", rd, !rows[i].wr);
         $display("access test %0d done", i);
      end
      i_master.access(1'b0, 19'h40123, row, col, we, rd, got);
      check("range ack", got, 1'b0);
      $display("range test done");
      repeat (400) @(posedge i_clock);
      check("refresh count", n_rf >= 2, 1'b1);
      $display("refresh test done");
      #10;
      i_reset_n = 1'b0;
      #10;
      check("reset strobes", strobe, 3'h7);
      check("reset acks", ack, 5'h00);
      repeat (2) @(posedge i_clock);
      #10;
      i_reset_n = 1'b1;
      i_master.access(1'b1, 19'h00155, row, col, we, rd, got);
      check("ack after reset", got, 1'b1);
      $display("reset test done");
      conclude();
   end
endmodule : testbench
`default_nettype wire
